/* include/rsq_pkg.sv */
// Purpose: Constants for the reset source and time-out sequencer
// Assumes: 50 MHz system clock, Wishbone classic register access
// Notes:   Offsets are byte addresses of 32-bit words
package rsq_pkg;
   localparam int unsigned CLK_HZ           = 50000000;
   localparam int unsigned POWER_UP_TIMER_MS          = 72;
   localparam int unsigned PLL_LOCK_MS      = 2;
   localparam int unsigned POWER_UP_TIMER_CYCLES      = (CLK_HZ / 1000) * POWER_UP_TIMER_MS;
   localparam int unsigned PLL_LOCK_CYCLES  = (CLK_HZ / 1000) * PLL_LOCK_MS;
   localparam int unsigned OST_CYCLES       = 1024;
   localparam int unsigned GLITCH_CYCLES    = 16;
   localparam int unsigned BOR_MIN_CYCLES   = 8;

   localparam logic [7:0] ADDR_RESET_CAUSE_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_CFG    = 8'h04;
   localparam logic [7:0] ADDR_STAT   = 8'h08;
   localparam logic [7:0] ADDR_SWRST  = 8'h0C;

   localparam int unsigned BIT_INTERRUPT_PRIORITY_ENABLE = 7;
   localparam int unsigned BIT_RI   = 4;
   localparam int unsigned BIT_TO   = 3;
   localparam int unsigned BIT_PD   = 2;
   localparam int unsigned BIT_POR  = 1;
   localparam int unsigned BIT_BOR  = 0;
   localparam logic [7:0] RESET_CAUSE_CONTROL_RESET = 8'h1D;
   localparam logic [7:0] RESET_CAUSE_CONTROL_MASK  = 8'h9F;

   // Config register fields
   localparam int unsigned CFG_POWER_UP_TIMER_DIS = 0;
   localparam int unsigned CFG_BOR_EN   = 1;
   localparam int unsigned CFG_OSC_LSB  = 2;
   localparam logic [3:0] CFG_RESET     = 4'h2;

   typedef enum logic [1:0] {
      OSC_XTAL = 2'b00,
      OSC_PLL  = 2'b01,
      OSC_EC   = 2'b10,
      OSC_RC   = 2'b11
   } rsq_osc_t;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_POWER_UP_TIMER = 3'b001,
      ST_OST  = 3'b010,
      ST_PLL  = 3'b011,
      ST_WAIT = 3'b100,
      ST_RUN  = 3'b101
   } rsq_state_t;
endpackage : rsq_pkg

/* rtl/rsq_top.sv */
// Purpose: Reset source and time-out sequencer with cause flags
// Assumes: Pins and analog detectors arrive asynchronously
// Notes:   Summary of operation follows
`timescale 1ns/1ps
module rsq_top #(
   parameter int unsigned POWER_UP_TIMER_CYC = rsq_pkg::POWER_UP_TIMER_CYCLES,
   parameter int unsigned PLL_CYC  = rsq_pkg::PLL_LOCK_CYCLES,
   parameter int unsigned OST_CYC  = rsq_pkg::OST_CYCLES,
   parameter int unsigned FILT_CYC = rsq_pkg::GLITCH_CYCLES
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        MASTER_CLEAR_PIN_N,
   input  wire logic        SUPPLY_GOOD,
   input  wire logic        BROWNOUT_LOW,
   input  wire logic        OSC_EDGE,
   input  wire logic        WATCHDOG_TIMER_EXPIRE,
   input  wire logic        STACK_FULL_EVT,
   input  wire logic        STACK_UNDERFLOW_EVT,
   input  wire logic        SLEEP_MODE,
   input  wire logic        INT_WAKE,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic        WB_WE_I,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             CORE_RESET_N,
   output logic             RESUME_PC2,
   output logic             WAKE_DONE,
   output logic             MASTER_CLEAR_OE_N
);
   // Two-stage synchronisers for asynchronous inputs
   // Only the second stage is read, so a metastable first stage never reaches logic
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= {INT_WAKE, SLEEP_MODE, STACK_UNDERFLOW_EVT, STACK_FULL_EVT,
                       WATCHDOG_TIMER_EXPIRE, OSC_EDGE, BROWNOUT_LOW, SUPPLY_GOOD};
         sync2_reg <= sync1_reg;
      end
   end
   logic master_clear_pin_s1_reg;
   logic master_clear_pin_s2_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         master_clear_pin_s1_reg <= 1'b1;
         master_clear_pin_s2_reg <= 1'b1;
      end else begin
         master_clear_pin_s1_reg <= MASTER_CLEAR_PIN_N;
         master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
      end
   end

   logic supply_ok, bor_low, osc_lvl, wdt_lvl, stkf_lvl, stku_lvl, sleeping, int_lvl;
   assign {int_lvl, sleeping, stku_lvl, stkf_lvl, wdt_lvl, osc_lvl, bor_low, supply_ok} = sync2_reg;

   // Edge history for pulse-type sources
   // Reset values equal the idle level of each source, so no false edge
   // follows reset; a supply already good still yields the power-on pulse
   logic [5:0] prev_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) prev_reg <= 6'h00;
      else prev_reg <= {int_lvl, stku_lvl, stkf_lvl, wdt_lvl, osc_lvl, supply_ok};
   end
   logic por_pulse, osc_rise, wdt_evt, stkf_evt, stku_evt, int_evt;
   assign por_pulse = supply_ok & ~prev_reg[0];
   assign osc_rise  = osc_lvl & ~prev_reg[1];
   assign wdt_evt   = wdt_lvl & ~prev_reg[2];
   assign stkf_evt  = stkf_lvl & ~prev_reg[3];
   assign stku_evt  = stku_lvl & ~prev_reg[4];
   assign int_evt   = int_lvl & ~prev_reg[5];

   // Glitch filter: pin state changes only after it holds FILT_CYC cycles
   // Trade-off: a genuine clear is also seen FILT_CYC cycles late, and a
   // pulse shorter than that is dropped however often it repeats
   logic [15:0] filt_cnt_reg;
   logic        master_clear_pin_low_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         filt_cnt_reg <= 16'h0000;
         master_clear_pin_low_reg <= 1'b0;
      end else if (master_clear_pin_s2_reg == ~master_clear_pin_low_reg) begin
         filt_cnt_reg <= 16'h0000;
      end else if (filt_cnt_reg == 16'(FILT_CYC - 1)) begin
         filt_cnt_reg <= 16'h0000;
         master_clear_pin_low_reg <= ~master_clear_pin_low_reg;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 16'h0001;
      end
   end
   logic master_clear_pin_prev_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) master_clear_pin_prev_reg <= 1'b0;
      else master_clear_pin_prev_reg <= master_clear_pin_low_reg;
   end
   logic master_clear_pin_evt;
   assign master_clear_pin_evt = master_clear_pin_low_reg & ~master_clear_pin_prev_reg;

   // Configuration and software reset
   logic [3:0] cfg_reg;
   logic       sw_evt_reg;
   logic       wb_hit;
   assign wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Lane 0 write strobe for one register address, shared by every register
   function automatic logic reg_write(input logic hit, input logic we, input logic [3:0] sel,
                                      input logic [7:0] adr, input logic [7:0] target);
      reg_write = hit & we & sel[0] & (adr == target);
   endfunction : reg_write
   rsq_pkg::rsq_osc_t osc_mode;
   assign osc_mode = rsq_pkg::rsq_osc_t'(cfg_reg[rsq_pkg::CFG_OSC_LSB +: 2]);
   logic power_up_timer_dis, bor_en;
   assign power_up_timer_dis = cfg_reg[rsq_pkg::CFG_POWER_UP_TIMER_DIS];
   assign bor_en   = cfg_reg[rsq_pkg::CFG_BOR_EN];

   // Brown-out needs BOR_MIN_CYCLES + 1 cycles of low supply to count
   // The count saturates, so a long dip holds the flag without wrapping
   logic [7:0] bor_cnt_reg;
   logic       bor_active_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         bor_cnt_reg    <= 8'h00;
         bor_active_reg <= 1'b0;
      end else if (!bor_en || !bor_low) begin
         bor_cnt_reg    <= 8'h00;
         bor_active_reg <= 1'b0;
      end else if (bor_cnt_reg == 8'(rsq_pkg::BOR_MIN_CYCLES)) begin
         bor_active_reg <= 1'b1;
      end else begin
         bor_cnt_reg <= bor_cnt_reg + 8'h01;
      end
   end
   logic bor_prev_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) bor_prev_reg <= 1'b0;
      else bor_prev_reg <= bor_active_reg;
   end
   logic bor_evt;
   assign bor_evt = bor_active_reg & ~bor_prev_reg;

   // Time-out sequencer
   // A power-on pulse or an active brown-out overrides every state, so a dip
   // inside the power-up delay restarts the whole chain from the top
   rsq_pkg::rsq_state_t state_reg;
   logic [31:0] cnt_reg;
   logic        wake_seq_reg;
   logic        pwr_seq;
   logic        ost_needed;
   logic        pll_mode;
   assign pll_mode   = (osc_mode == rsq_pkg::OSC_PLL);
   assign ost_needed = (osc_mode == rsq_pkg::OSC_XTAL) | pll_mode;
   assign pwr_seq    = por_pulse | bor_active_reg;

   function automatic rsq_pkg::rsq_state_t after_power_up_timer(input logic osc_startup_timer, input logic pll);
      if (osc_startup_timer) after_power_up_timer = rsq_pkg::ST_OST;
      else if (pll) after_power_up_timer = rsq_pkg::ST_PLL;
      else after_power_up_timer = rsq_pkg::ST_WAIT;
   endfunction : after_power_up_timer

   // Wake-ups keep the core released; only the start-up and lock waits run
   logic wake_req;
   assign wake_req = sleeping & (int_evt | wdt_evt) & (state_reg == rsq_pkg::ST_RUN);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg    <= rsq_pkg::ST_HOLD;
         cnt_reg      <= 32'h0000_0000;
         wake_seq_reg <= 1'b0;
      end else if (pwr_seq) begin
         state_reg    <= rsq_pkg::ST_HOLD;
         cnt_reg      <= 32'h0000_0000;
         wake_seq_reg <= 1'b0;
      end else begin
         case (state_reg)
            rsq_pkg::ST_HOLD: begin
               // Nothing counts until the supply is reported good
               cnt_reg <= 32'h0000_0000;
               if (supply_ok) begin
                  if (!power_up_timer_dis) state_reg <= rsq_pkg::ST_POWER_UP_TIMER;
                  else state_reg <= after_power_up_timer(ost_needed, pll_mode);
               end
            end
            rsq_pkg::ST_POWER_UP_TIMER: begin
               if (cnt_reg == POWER_UP_TIMER_CYC - 1) begin
                  cnt_reg   <= 32'h0000_0000;
                  state_reg <= after_power_up_timer(ost_needed, pll_mode);
               end else cnt_reg <= cnt_reg + 32'h0000_0001;
            end
            rsq_pkg::ST_OST: begin
               if (osc_rise) begin
                  if (cnt_reg == OST_CYC - 1) begin
                     cnt_reg   <= 32'h0000_0000;
                     state_reg <= pll_mode ? rsq_pkg::ST_PLL : rsq_pkg::ST_WAIT;
                  end else cnt_reg <= cnt_reg + 32'h0000_0001;
               end
            end
            rsq_pkg::ST_PLL: begin
               if (cnt_reg == PLL_CYC - 1) begin
                  cnt_reg   <= 32'h0000_0000;
                  state_reg <= rsq_pkg::ST_WAIT;
               end else cnt_reg <= cnt_reg + 32'h0000_0001;
            end
            rsq_pkg::ST_WAIT: begin
               if (!master_clear_pin_low_reg) state_reg <= rsq_pkg::ST_RUN;
            end
            rsq_pkg::ST_RUN: begin
               cnt_reg <= 32'h0000_0000;
               if (master_clear_pin_evt || wdt_evt && !sleeping || sw_evt_reg || stkf_evt || stku_evt) begin
                  state_reg    <= rsq_pkg::ST_WAIT;
                  wake_seq_reg <= 1'b0;
               end else if (wake_req) begin
                  wake_seq_reg <= 1'b1;
                  state_reg    <= ost_needed ? rsq_pkg::ST_OST : rsq_pkg::ST_WAIT;
               end
            end
            default: state_reg <= rsq_pkg::ST_HOLD;
         endcase
      end
   end

   // Outputs
   // The clear pin is never driven, so a watchdog reset stays inside the chip
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_RESET_N      <= 1'b0;
         RESUME_PC2        <= 1'b0;
         WAKE_DONE         <= 1'b0;
         MASTER_CLEAR_OE_N <= 1'b1;
      end else begin
         CORE_RESET_N      <= (state_reg == rsq_pkg::ST_RUN) | wake_seq_reg;
         RESUME_PC2        <= wake_seq_reg;
         WAKE_DONE         <= wake_seq_reg & (state_reg == rsq_pkg::ST_WAIT);
         MASTER_CLEAR_OE_N <= 1'b1;
      end
   end

   // Cause register
   // One cause per cycle in fixed priority; a bus write in the same cycle
   // loses to the hardware update of any flag that the event touches
   logic [7:0] reset_cause_control_reg;
   logic [1:0] stk_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         reset_cause_control_reg <= rsq_pkg::RESET_CAUSE_CONTROL_RESET;
      end else begin
         if (reg_write(wb_hit, WB_WE_I, WB_SEL_I, WB_ADR_I, rsq_pkg::ADDR_RESET_CAUSE_CONTROL))
            reset_cause_control_reg <= WB_DAT_I[7:0] & rsq_pkg::RESET_CAUSE_CONTROL_MASK;
         if (por_pulse) begin
            reset_cause_control_reg[rsq_pkg::BIT_RI]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_TO]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_PD]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_POR] <= 1'b0;
            reset_cause_control_reg[rsq_pkg::BIT_BOR] <= 1'b0;
         end else if (bor_evt) begin
            reset_cause_control_reg[rsq_pkg::BIT_RI]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_TO]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_PD]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_BOR] <= 1'b0;
         end else if (master_clear_pin_evt && sleeping) begin
            reset_cause_control_reg[rsq_pkg::BIT_TO]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_PD]  <= 1'b0;
         end else if (wdt_evt) begin
            reset_cause_control_reg[rsq_pkg::BIT_TO]  <= 1'b0;
            reset_cause_control_reg[rsq_pkg::BIT_PD]  <= ~sleeping;
         end else if (sw_evt_reg) begin
            reset_cause_control_reg[rsq_pkg::BIT_RI]  <= 1'b0;
         end else if (stkf_evt || stku_evt) begin
            reset_cause_control_reg[rsq_pkg::BIT_POR] <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_BOR] <= 1'b1;
         end else if (int_evt && sleeping) begin
            reset_cause_control_reg[rsq_pkg::BIT_TO]  <= 1'b1;
            reset_cause_control_reg[rsq_pkg::BIT_PD]  <= 1'b0;
         end
      end
   end
   // Stack flags: hardware set wins over software clear
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) stk_reg <= 2'b00;
      else begin
         if (reg_write(wb_hit, WB_WE_I, WB_SEL_I, WB_ADR_I, rsq_pkg::ADDR_STAT))
            stk_reg <= stk_reg & ~WB_DAT_I[1:0];
         if (stkf_evt) stk_reg[0] <= 1'b1;
         if (stku_evt) stk_reg[1] <= 1'b1;
      end
   end

   // Wishbone slave: one-cycle ack, config and software reset strobe
   // Requests are taken only while ack is low, so a held request acks every other cycle
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg    <= rsq_pkg::CFG_RESET;
         sw_evt_reg <= 1'b0;
      end else begin
         sw_evt_reg <= reg_write(wb_hit, WB_WE_I, WB_SEL_I, WB_ADR_I, rsq_pkg::ADDR_SWRST) & WB_DAT_I[0];
         if (reg_write(wb_hit, WB_WE_I, WB_SEL_I, WB_ADR_I, rsq_pkg::ADDR_CFG))
            cfg_reg <= WB_DAT_I[3:0];
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_hit;
         if (!wb_hit) WB_DAT_O <= 32'h0000_0000;
         else if (WB_ADR_I == rsq_pkg::ADDR_RESET_CAUSE_CONTROL) WB_DAT_O <= {24'h000000, reset_cause_control_reg};
         else if (WB_ADR_I == rsq_pkg::ADDR_CFG) WB_DAT_O <= {28'h0000000, cfg_reg};
         else if (WB_ADR_I == rsq_pkg::ADDR_STAT)
            WB_DAT_O <= {26'h0000000, state_reg, master_clear_pin_low_reg, stk_reg};
         else WB_DAT_O <= 32'h0000_0000;
      end
   end
endmodule : rsq_top

/* dv/rsq_far_model.sv */
// Purpose: Pin, supply monitor and oscillator beside the sequencer
// Assumes: Clear pin pulled up when nobody holds it low
// Notes:   Oscillator rises every 4 system cycles
`timescale 1ns/1ps
module rsq_far_model (
   input  wire logic clk,
   input  wire logic supply_on,
   input  wire logic clr_hold,
   input  wire logic dip,
   output logic      clr_pin_n,
   output logic      supply_good,
   output logic      brownout_low,
   output logic      osc_edge
);
   logic [1:0] div_reg;
   // A dead supply stops the crystal, so no edges come while it is off
   always_ff @(posedge clk) begin
      div_reg <= supply_on ? div_reg + 2'h1 : 2'h0;
   end
   assign osc_edge     = div_reg[1];
   assign supply_good  = supply_on;
   assign brownout_low = dip;
   assign clr_pin_n    = ~clr_hold;
endmodule : rsq_far_model

/* dv/rsq_top_asserts.sv */
// Purpose: Port-level checks on the reset sequencer
// Assumes: One clock domain
// Notes:   Config is shadowed from bus writes
`timescale 1ns/1ps
module rsq_top_asserts #(
   parameter int unsigned POWER_UP_TIMER_CYC = rsq_pkg::POWER_UP_TIMER_CYCLES
) (
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        MASTER_CLEAR_PIN_N,
   input wire logic        SUPPLY_GOOD,
   input wire logic        BROWNOUT_LOW,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic        WB_WE_I,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        CORE_RESET_N,
   input wire logic        RESUME_PC2,
   input wire logic        MASTER_CLEAR_OE_N
);
   logic [3:0]  cfg_reg;
   logic [31:0] up_reg;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) cfg_reg <= rsq_pkg::CFG_RESET;
      else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == rsq_pkg::ADDR_CFG)
         cfg_reg <= WB_DAT_I[3:0];
   end
   // Cycles of healthy supply; a dip restarts it
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) up_reg <= 32'h0;
      else up_reg <= (SUPPLY_GOOD && !BROWNOUT_LOW) ? up_reg + 32'h1 : 32'h0;
   end
   chk_clear_undriven: assert property (MASTER_CLEAR_OE_N == 1'b1)
      else $error("clear pin output enable active");
   chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not acknowledged next cycle");
   chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("acknowledge longer than one cycle");
   chk_cause_layout: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == rsq_pkg::ADDR_RESET_CAUSE_CONTROL |->
      WB_DAT_O[31:8] == 24'h0 && WB_DAT_O[6:5] == 2'b00) else $error("unimplemented cause bits read nonzero");
   chk_release_pin: assert property ($rose(CORE_RESET_N) |-> MASTER_CLEAR_PIN_N && $past(MASTER_CLEAR_PIN_N, 3))
      else $error("core released while clear pin low");
   chk_power_up_timer_delay: assert property ($rose(CORE_RESET_N) && !cfg_reg[0] |-> up_reg > POWER_UP_TIMER_CYC)
      else $error("core released before power-up delay");
   chk_brownout_hold: assert property (cfg_reg[1] throughout (BROWNOUT_LOW [*8] ##1 BROWNOUT_LOW [*8])
      |=> !CORE_RESET_N) else $error("long supply dip did not hold reset");
   chk_wake_runs: assert property ($rose(RESUME_PC2) |-> CORE_RESET_N && $past(CORE_RESET_N))
      else $error("wake-up dropped core reset");
   chk_por_reset: assert property ($rose(SUPPLY_GOOD) |-> ##[1:8] !CORE_RESET_N)
      else $error("supply rise gave no reset");
   cover property ($rose(CORE_RESET_N));
   cover property ($rose(RESUME_PC2));
   cover property (cfg_reg[3:2] == 2'b01 && $rose(CORE_RESET_N));
endmodule : rsq_top_asserts
bind rsq_top rsq_top_asserts #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC)) u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .SUPPLY_GOOD(SUPPLY_GOOD), .BROWNOUT_LOW(BROWNOUT_LOW),
   .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CORE_RESET_N(CORE_RESET_N),
   .RESUME_PC2(RESUME_PC2), .MASTER_CLEAR_OE_N(MASTER_CLEAR_OE_N));

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short timers (50, 8, 20 cycles), 50 MHz clock
// Notes:   Random cause presets from a fixed seed
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, sup_on = 1'b0, clr_hold = 1'b0, dip = 1'b0;
   logic        wd = 1'b0, sf = 1'b0, su = 1'b0, slp = 1'b0, iw = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pin_n, sgood, blow, osc, ack, core_n, pc2, oe_n, wdn;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q, t, p;
   integer      seed = 44779, n_fail = 0, num_checks = 0, m, e, n_wake = 0;
   always #10 clk = ~clk;
   // Each wake-up should pass through its wait state exactly once
   always @(posedge clk)
      if (wdn === 1'b1) n_wake <= n_wake + 1;
   rsq_far_model u_far (.clk(clk), .supply_on(sup_on), .clr_hold(clr_hold), .dip(dip),
      .clr_pin_n(pin_n), .supply_good(sgood), .brownout_low(blow), .osc_edge(osc));
   rsq_top #(.POWER_UP_TIMER_CYC(50), .PLL_CYC(20), .OST_CYC(8), .FILT_CYC(16)) dut (.REF_CLK(clk), .RST_N(rst_n),
      .MASTER_CLEAR_PIN_N(pin_n), .SUPPLY_GOOD(sgood), .BROWNOUT_LOW(blow), .OSC_EDGE(osc),
      .WATCHDOG_TIMER_EXPIRE(wd), .STACK_FULL_EVT(sf), .STACK_UNDERFLOW_EVT(su), .SLEEP_MODE(slp),
      .INT_WAKE(iw), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CORE_RESET_N(core_n), .RESUME_PC2(pc2),
      .WAKE_DONE(wdn), .MASTER_CLEAR_OE_N(oe_n));
   task automatic stop_test;
      $display("checks=%0d errors=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // Nonzero slack accepts a window, for latencies set by synchronisers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] sl);
      logic ok;
      ok = (sl == 0) ? (got === exp) : (got >= exp && got <= exp + sl);
      num_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge clk);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1, 32'h0);
   endtask : bus
   task automatic wait_up(output logic [31:0] c);
      c = 0;
      while (core_n !== 1'b1 && c < 3000) begin
         @(posedge clk);
         c = c + 1;
      end
   endtask : wait_up
   task automatic ev(input integer k);
      if (k < 2) begin
         slp <= (k == 1);
         repeat (3) @(posedge clk);
         clr_hold <= 1'b1;
         repeat (30) @(posedge clk);
         clr_hold <= 1'b0;
      end else if (k == 4) bus(rsq_pkg::ADDR_SWRST, 1'b1, 32'h1);
      else if (k == 8) begin
         // Second dip lands inside the power-up delay
         dip <= 1'b1;
         repeat (20) @(posedge clk);
         dip <= 1'b0;
         repeat (30) @(posedge clk);
         dip <= 1'b1;
         repeat (20) @(posedge clk);
         dip <= 1'b0;
      end else begin
         slp <= (k == 3 || k == 7);
         repeat (3) @(posedge clk);
         wd <= (k == 2 || k == 3);
         sf <= (k == 5);
         su <= (k == 6);
         iw <= (k == 7);
         repeat (3) @(posedge clk);
         {wd, sf, su, iw} <= 4'h0;
      end
   endtask : ev
   // Cause bits: 4 sw-reset, 3 time-out, 2 power-down, 1 power-on, 0 brown-out
   function automatic logic [31:0] exp_reset_cause_control(input integer k, input logic [31:0] v);
      logic [7:0] r;
      r = v[7:0] & 8'h9F;
      case (k)
         1, 7: r[3:2] = 2'b10;
         2: r[3:2] = 2'b01;
         3: r[3:2] = 2'b00;
         4: r[4] = 1'b0;
         5, 6: r[1:0] = 2'b11;
         8: r = {r[7:5], 3'b111, r[1], 1'b0};
         default: r = r;
      endcase
      return {24'h0, r};
   endfunction : exp_reset_cause_control
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(rsq_pkg::ADDR_RESET_CAUSE_CONTROL, 1'b0, 32'h0);
      chk(q, 32'h1D, 32'h0);
      bus(8'h10, 1'b1, 32'hFF);
      bus(8'h10, 1'b0, 32'h0);
      chk(q, 32'h0, 32'h0);
      for (m = 0; m < 8; m++) begin
         sup_on <= 1'b0;
         bus(rsq_pkg::ADDR_CFG, 1'b1, {28'h0, m[2:1], 1'b1, m[0]});
         repeat (5) @(posedge clk);
         sup_on <= 1'b1;
         // Losing the supply does not reset the core; the power-on pulse does
         repeat (5) @(posedge clk);
         chk(core_n, 32'h0, 32'h0);
         wait_up(t);
         chk(t, (m[0] ? 0 : 50) + (m[2] ? 0 : 28) + (m[2:1] == 1 ? 20 : 0), 32'd16);
      end
      bus(rsq_pkg::ADDR_RESET_CAUSE_CONTROL, 1'b0, 32'h0);
      chk(q & 32'h1F, 32'h1C, 32'h0);
      bus(rsq_pkg::ADDR_CFG, 1'b1, 32'h2);
      clr_hold <= 1'b1;
      sup_on <= 1'b0;
      repeat (5) @(posedge clk);
      sup_on <= 1'b1;
      repeat (300) @(posedge clk);
      chk(core_n, 32'h0, 32'h0);
      clr_hold <= 1'b0;
      wait_up(t);
      chk(t, 32'h0, 32'd26);
      bus(rsq_pkg::ADDR_CFG, 1'b1, 32'h6);
      clr_hold <= 1'b1;
      repeat (2 + ($random(seed) & 7)) @(posedge clk);
      clr_hold <= 1'b0;
      repeat (30) @(posedge clk);
      chk(core_n, 32'h1, 32'h0);
      for (e = 0; e < 9; e++) begin
         p = $random(seed);
         bus(rsq_pkg::ADDR_RESET_CAUSE_CONTROL, 1'b1, p);
         ev(e);
         wait_up(t);
         if (e == 8) chk(t, 32'd98, 32'd16);
         repeat (60) @(posedge clk);
         chk(pc2, e == 3 || e == 7, 32'h0);
         chk(oe_n, 32'h1, 32'h0);
         slp <= 1'b0;
         bus(rsq_pkg::ADDR_RESET_CAUSE_CONTROL, 1'b0, 32'h0);
         chk(q, exp_reset_cause_control(e, p), 32'h0);
      end
      bus(rsq_pkg::ADDR_STAT, 1'b0, 32'h0);
      chk(q, {26'h0, rsq_pkg::ST_RUN, 3'b011}, 32'h0);
      bus(rsq_pkg::ADDR_STAT, 1'b1, 32'h3);
      bus(rsq_pkg::ADDR_STAT, 1'b0, 32'h0);
      chk(q, {26'h0, rsq_pkg::ST_RUN, 3'b000}, 32'h0);
      chk(n_wake, 32'h2, 32'h0);
      stop_test();
   end
endmodule : tb_top
